//--- rtl/lfs_pkg.sv
// Shared constants for the two-channel LED fault supervisor
package lfs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;      // 200 MHz reference clock
  localparam int OPEN_DEG_NS     = 20000;  // Open deglitch time
  localparam int SG_DEG_NS       = 20000;  // Short-to-ground deglitch time
  localparam int TSD_DEG_NS      = 10000;  // Thermal deglitch time
  localparam int RECOVERY_NS     = 20000;  // Fault bus recovery delay
  // Least times round up to whole cycles
  localparam int OPEN_DEG_CYC    = (OPEN_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SG_DEG_CYC      = (SG_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TSD_DEG_CYC     = (TSD_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 16;     // Width of every deglitch counter

  // ----------------------------------------------------------------
  // Channels and synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int NUM_CH          = 2;
  localparam int SY_DIAG         = 0;      // Open-detect enable
  localparam int SY_DIM          = 1;      // Dimming inputs, 2 bits
  localparam int SY_HRLO         = 3;      // Headroom below open rising, 2 bits
  localparam int SY_HRHI         = 5;      // Headroom above open falling, 2 bits
  localparam int SY_OUTLO        = 7;      // Direct output below short falling, 2 bits
  localparam int SY_SHLO         = 9;      // Shunt output below short falling, 2 bits
  localparam int SY_SGCLR        = 11;     // Outputs above short rising, 2 bits
  localparam int SY_TOVER        = 13;     // Junction at shutdown temperature
  localparam int SY_TCOOL        = 14;     // Junction below shutdown minus hysteresis
  localparam int SY_BUS          = 15;     // Fault bus level
  localparam int SY_W            = 16;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low address byte decoded)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF    = 8'h00;  // Control register
  localparam logic [7:0] STATUS_OFF  = 8'h04;  // Status register, read only
  localparam int         CTRL_EN_BIT = 0;      // Output enable bit
  localparam logic       CTRL_RESET  = 1'h1;   // Outputs allowed after reset
  localparam int         ST_OPEN     = 0;      // Open faults, 2 bits
  localparam int         ST_SHORT    = 2;      // Short-to-ground faults, 2 bits
  localparam int         ST_THERM    = 4;      // Thermal shutdown active
  localparam int         ST_BUSLOW   = 5;      // Fault bus sensed low
  localparam int         ST_RECOV    = 6;      // Recovery delay elapsed
  localparam int         ST_REG      = 7;      // Channels regulating, 2 bits

endpackage

//--- rtl/lfs_deglitch.sv
// Deglitch / delay counter: expires after arm held for COUNT cycles
module lfs_deglitch #(
  parameter int unsigned COUNT = lfs_pkg::OPEN_DEG_CYC,
  parameter int          CW    = lfs_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Condition
  input  wire logic arm,
  input  wire logic kill,
  // Result
  output logic      expired
);
  import lfs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt;                 // Cycles the condition has held
  } lfs_dg_state_t;

  localparam logic [CW-1:0] LIMIT = CW'(COUNT);

  lfs_dg_state_t st_reg;                // Registered state
  lfs_dg_state_t st_next;               // Next state

  // Refuse counts that the counter cannot hold
  if (COUNT < 1 || COUNT >= (64'd1 << CW))
  begin : g_bad_count
    $error("lfs_deglitch: COUNT out of range");
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Kill wins; between thresholds the count holds, giving hysteresis
  always_comb
  begin
    st_next = st_reg;
    if (kill)
    begin
      st_next.cnt = '0;
    end
    else if (arm && st_reg.cnt != LIMIT)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  // Registered copy
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign expired = (st_reg.cnt == LIMIT);

endmodule

//--- rtl/lfs_supervisor.sv
// Fault supervisor for a two-channel LED driver with a shared fault bus
// Functional notes
// - Open check needs detect enable and dimming high
// - Short-to-battery handled as open fault
// - Open fault after low headroom for deglitch
// - Headroom above falling threshold resets open timer
// - Open fault pulls fault bus low
// - Failed channel off, retry while detect enabled
// - Fault gone: regulate again, release bus
// - Detect enable input gates open detection
// - Short and thermal checks ignore detect enable
// - Thermal shutdown with hysteresis turns all off
// - Bus held low during thermal shutdown
// - Bus weakly high, strongly low on fault
// - External bus low turns outputs off
// - Outputs stay off until bus high again
// - Bus low with fault: retry, recover after delay
// - Bus low without fault: all channels off
// - Short on either output, deglitched, then retry
// - Dimming low disables regulation current and diagnostics, not retry current
// - Short cleared when outputs rise above threshold
module lfs_supervisor #(
  parameter int OPEN_DEG_CYC = lfs_pkg::OPEN_DEG_CYC,
  parameter int SG_DEG_CYC   = lfs_pkg::SG_DEG_CYC,
  parameter int TSD_DEG_CYC  = lfs_pkg::TSD_DEG_CYC,
  parameter int RECOV_CYC    = lfs_pkg::RECOVERY_CYC
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Control pins
  input  wire logic                       open_detect_enable,
  input  wire logic [lfs_pkg::NUM_CH-1:0] channel_dim_input,
  // Comparator results per channel
  input  wire logic [lfs_pkg::NUM_CH-1:0] headroom_below_open_rise,
  input  wire logic [lfs_pkg::NUM_CH-1:0] headroom_above_open_fall,
  input  wire logic [lfs_pkg::NUM_CH-1:0] direct_below_short_fall,
  input  wire logic [lfs_pkg::NUM_CH-1:0] shunt_below_short_fall,
  input  wire logic [lfs_pkg::NUM_CH-1:0] outputs_above_short_rise,
  // Temperature comparators
  input  wire logic                       temp_at_shutdown,
  input  wire logic                       temp_below_hysteresis,
  // Open-drain fault bus
  input  wire logic                       fault_bus_i,
  output logic                            fault_bus_o,
  output logic                            fault_bus_oe_n,
  // Channel drive
  output logic [lfs_pkg::NUM_CH-1:0]      channel_regulate_en,
  output logic [lfs_pkg::NUM_CH-1:0]      channel_retry_en,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic [31:0]                     hrdata,
  output logic                            hresp
);
  import lfs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SY_W-1:0]   sync1;     // First synchroniser stage
    logic [SY_W-1:0]   sync2;     // Second synchroniser stage
    logic              ctrl_en;   // Software output enable
    logic [NUM_CH-1:0] open_flt;  // Latched open / short-to-battery faults
    logic [NUM_CH-1:0] short_flt; // Latched short-to-ground faults
    logic              therm;     // Thermal shutdown active
    logic              wr_pend;   // Write data phase pending
    logic [7:0]        addr;      // Address of pending write
    logic [31:0]       rdata;     // Read data for the data phase
  } lfs_state_t;

  lfs_state_t        st_reg;      // Registered state
  lfs_state_t        st_next;     // Next state
  logic [SY_W-1:0]   pins_raw;    // Asynchronous inputs gathered
  logic              diag_s;      // Synchronised levels
  logic [NUM_CH-1:0] dim_s;
  logic [NUM_CH-1:0] hr_lo_s;
  logic [NUM_CH-1:0] hr_hi_s;
  logic [NUM_CH-1:0] out_lo_s;
  logic [NUM_CH-1:0] sh_lo_s;
  logic [NUM_CH-1:0] sg_clr_s;
  logic              t_over_s;
  logic              t_cool_s;
  logic              bus_s;
  logic [NUM_CH-1:0] open_exp;    // Open deglitch expired
  logic [NUM_CH-1:0] short_exp;   // Short deglitch expired
  logic              therm_exp;   // Thermal deglitch expired
  logic              recovered;   // Bus high for the recovery delay
  logic [NUM_CH-1:0] drive_on;    // Channel regulating
  logic [NUM_CH-1:0] retry_on;    // Channel sourcing retry current
  logic              own_fault;   // Any local fault
  logic              addr_ok;     // AHB address phase accepted

  // Refuse recovery delays the cover and check window cannot serve
  if (RECOV_CYC < 2)
  begin : g_bad_recov
    $error("lfs_supervisor: RECOV_CYC must be at least 2");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  // Every pin except reset and the AHB-Lite bus passes two flops before any logic looks at it
  assign pins_raw = {fault_bus_i, temp_below_hysteresis, temp_at_shutdown,
                     outputs_above_short_rise, shunt_below_short_fall,
                     direct_below_short_fall, headroom_above_open_fall,
                     headroom_below_open_rise, channel_dim_input,
                     open_detect_enable};
  assign diag_s   = st_reg.sync2[SY_DIAG];
  assign dim_s    = st_reg.sync2[SY_DIM +: NUM_CH];
  assign hr_lo_s  = st_reg.sync2[SY_HRLO +: NUM_CH];
  assign hr_hi_s  = st_reg.sync2[SY_HRHI +: NUM_CH];
  assign out_lo_s = st_reg.sync2[SY_OUTLO +: NUM_CH];
  assign sh_lo_s  = st_reg.sync2[SY_SHLO +: NUM_CH];
  assign sg_clr_s = st_reg.sync2[SY_SGCLR +: NUM_CH];
  assign t_over_s = st_reg.sync2[SY_TOVER];
  assign t_cool_s = st_reg.sync2[SY_TCOOL];
  assign bus_s    = st_reg.sync2[SY_BUS];

  // ----------------------------------------------------------------
  // Channel drive
  // ----------------------------------------------------------------
  // Regulation needs dimming, no local fault, no thermal shutdown and a
  // fault bus that has stood high for the recovery delay
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      drive_on[c] = dim_s[c] & ~st_reg.open_flt[c] & ~st_reg.short_flt[c]
                    & ~st_reg.therm & recovered & st_reg.ctrl_en;
      retry_on[c] = ~st_reg.therm
                    & ((st_reg.open_flt[c] & diag_s) | st_reg.short_flt[c]);
    end
  end

  assign own_fault           = (|st_reg.open_flt) | (|st_reg.short_flt) | st_reg.therm;
  assign channel_regulate_en = drive_on;
  assign channel_retry_en    = retry_on;
  // Only ever pulls low; the weak pull-up is analog and outside this logic
  assign fault_bus_o         = 1'b0;
  assign fault_bus_oe_n      = ~own_fault;

  // ----------------------------------------------------------------
  // Deglitch counters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    // Open check: headroom low; short-to-battery shows the same way
    lfs_deglitch #(
      .COUNT (OPEN_DEG_CYC),
      .CW    (CNT_W)
    ) u_open (
      .ref_clk (ref_clk),
      .rst     (rst),
      .arm     (diag_s & drive_on[g] & hr_lo_s[g]),
      .kill    (~(diag_s & drive_on[g]) | hr_hi_s[g]),
      .expired (open_exp[g])
    );
    // Short check: either output low, independent of detect enable
    lfs_deglitch #(
      .COUNT (SG_DEG_CYC),
      .CW    (CNT_W)
    ) u_short (
      .ref_clk (ref_clk),
      .rst     (rst),
      .arm     (drive_on[g] & (out_lo_s[g] | sh_lo_s[g])),
      .kill    (~drive_on[g] | sg_clr_s[g]),
      .expired (short_exp[g])
    );
  end

  // Thermal deglitch; restarts whenever the junction drops back
  lfs_deglitch #(
    .COUNT (TSD_DEG_CYC),
    .CW    (CNT_W)
  ) u_therm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .arm     (t_over_s),
    .kill    (~t_over_s),
    .expired (therm_exp)
  );

  // Bus recovery delay; any low sample on the bus restarts it
  lfs_deglitch #(
    .COUNT (RECOV_CYC),
    .CW    (CNT_W)
  ) u_recov (
    .ref_clk (ref_clk),
    .rst     (rst),
    .arm     (bus_s),
    .kill    (~bus_s),
    .expired (recovered)
  );

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfs_read(input logic [7:0] a, input lfs_state_t s,
                                           input logic bl, input logic rc,
                                           input logic [NUM_CH-1:0] rg);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == CTRL_OFF)
    begin
      v[CTRL_EN_BIT] = s.ctrl_en;
    end
    else if (a == STATUS_OFF)
    begin
      v[ST_OPEN +: NUM_CH]  = s.open_flt;
      v[ST_SHORT +: NUM_CH] = s.short_flt;
      v[ST_THERM]           = s.therm;
      v[ST_BUSLOW]          = bl;
      v[ST_RECOV]           = rc;
      v[ST_REG +: NUM_CH]   = rg;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign addr_ok = hsel & htrans[1] & hready;

  always_comb
  begin
    st_next       = st_reg;
    st_next.sync1 = pins_raw;
    st_next.sync2 = st_reg.sync1;
    for (int c = 0; c < NUM_CH; c++)
    begin
      // Fault latches; a count left over once the check stops is ignored
      if (open_exp[c] && diag_s && drive_on[c])
      begin
        st_next.open_flt[c] = 1'b1;
      end
      else if (!diag_s || hr_hi_s[c])
      begin
        st_next.open_flt[c] = 1'b0;
      end
      if (short_exp[c] && drive_on[c])
      begin
        st_next.short_flt[c] = 1'b1;
      end
      else if (sg_clr_s[c])
      begin
        st_next.short_flt[c] = 1'b0;
      end
    end
    // Thermal shutdown holds until below the hysteresis point
    if (therm_exp)
    begin
      st_next.therm = 1'b1;
    end
    else if (t_cool_s)
    begin
      st_next.therm = 1'b0;
    end
    // Bus: capture address phase, complete write in data phase
    st_next.wr_pend = addr_ok & hwrite;
    st_next.addr    = haddr[7:0];
    if (addr_ok && !hwrite)
    begin
      st_next.rdata = lfs_read(haddr[7:0], st_reg, ~bus_s, recovered, drive_on);
    end
    if (st_reg.wr_pend && st_reg.addr == CTRL_OFF)
    begin
      st_next.ctrl_en = hwdata[CTRL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_reg         <= '0;
      st_reg.ctrl_en <= CTRL_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_open_gate: assert property ($rose(st_reg.open_flt[0]) |-> $past(diag_s && dim_s[0]))
    else $error("open fault set without enable and dimming");
  chk_bus_pull: assert property (own_fault |-> !fault_bus_oe_n && !fault_bus_o)
    else $error("fault bus not pulled low on own fault");
  chk_bus_release: assert property ($fell(own_fault) |-> fault_bus_oe_n)
    else $error("fault bus held after fault cleared");
  chk_open_retry: assert property (st_reg.open_flt[0] && diag_s && !st_reg.therm
                                   |-> channel_retry_en[0] && !channel_regulate_en[0])
    else $error("failed channel not retrying");
  chk_open_clear: assert property (st_reg.open_flt[0] && hr_hi_s[0] |=> !st_reg.open_flt[0])
    else $error("open fault did not clear");
  chk_diag_off: assert property (!diag_s |=> !st_reg.open_flt[0] ##1 !st_reg.open_flt[0])
    else $error("open fault while detection disabled");
  chk_therm_off: assert property (st_reg.therm |-> channel_regulate_en == '0
                                  && channel_retry_en == '0 && !fault_bus_oe_n)
    else $error("outputs on or bus released during thermal shutdown");
  chk_ext_off: assert property (!bus_s |=> channel_regulate_en == '0)
    else $error("regulating while fault bus low");
  chk_recov_hold: assert property ($rose(bus_s) |-> channel_regulate_en == '0
                                   ##1 channel_regulate_en == '0)
    else $error("outputs back before recovery delay");
  chk_short_retry: assert property (st_reg.short_flt[0] && !st_reg.therm
                                    |-> channel_retry_en[0] && !channel_regulate_en[0])
    else $error("short channel not retrying");
  chk_short_clear: assert property (st_reg.short_flt[0] && sg_clr_s[0] |=> !st_reg.short_flt[0])
    else $error("short fault did not clear");

  cov_open_fault:  cover property ($rose(st_reg.open_flt[0]));
  cov_short_fault: cover property ($rose(st_reg.short_flt[1]));
  cov_therm:       cover property ($rose(st_reg.therm));
  cov_ext_bus:     cover property (!bus_s && !own_fault && $past(channel_regulate_en[0]));

endmodule

//--- dv/lfs_bus_peer.sv
// Model of another LED driver sharing the open-drain fault bus
module lfs_bus_peer
(
  // Clock
  input  wire logic ref_clk,
  // Fault of the far driver, commanded by the bench
  input  wire logic peer_fault,
  // Open-drain pull, low while pulling the bus down
  output logic      peer_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Weak pull-up at rest, strong pull-down while its fault stands
  initial peer_oe_n = 1'b1;
  always @(posedge ref_clk)
  begin
    peer_oe_n <= ~peer_fault;
  end
endmodule

//--- dv/lfs_supervisor_tb.sv
// Self-checking bench for the LED fault supervisor
module lfs_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lfs_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int DEG = 8;                  // Shortened counts keep the run brief
  localparam int WT  = 30;                 // Longer than any deglitch plus sync
  localparam logic [31:0] M = 32'he00001bf; // Pins and status fields compared
  logic ref_clk = 1'b0, rst = 1'b1, diag = 1'b0, t_at = 1'b0, t_cool = 1'b1;
  logic [1:0] dim = 2'b11, hr_lo = 2'b00, hr_hi = 2'b11, dlo = 2'b00, slo = 2'b00;
  logic [1:0] sgclr = 2'b11, htrans = 2'h0, reg_en, retry_en, oh, sc;
  logic hsel = 1'b0, hwrite = 1'b0, peer_fault = 1'b0, rd_dp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs, ev, em;
  logic hreadyout, hresp, bus_o, oe_n, peer_oe_n, bus_i, hready;
  logic [31:0] exp_v[$], exp_m[$];
  int fail_count = 0, compares = 0, seed = 28049, k;

  // Open-drain wire with pull-up: low when any party pulls
  assign bus_i  = oe_n & peer_oe_n;
  assign hready = hreadyout;

  lfs_supervisor #(.OPEN_DEG_CYC(DEG), .SG_DEG_CYC(DEG), .TSD_DEG_CYC(DEG),
    .RECOV_CYC(DEG)) lfs_supervisor_i (.ref_clk(ref_clk), .rst(rst),
    .open_detect_enable(diag), .channel_dim_input(dim),
    .headroom_below_open_rise(hr_lo), .headroom_above_open_fall(hr_hi),
    .direct_below_short_fall(dlo), .shunt_below_short_fall(slo),
    .outputs_above_short_rise(sgclr), .temp_at_shutdown(t_at),
    .temp_below_hysteresis(t_cool), .fault_bus_i(bus_i), .fault_bus_o(bus_o),
    .fault_bus_oe_n(oe_n), .channel_regulate_en(reg_en), .channel_retry_en(retry_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));

  lfs_bus_peer lfs_bus_peer_i (.ref_clk(ref_clk), .peer_fault(peer_fault),
    .peer_oe_n(peer_oe_n));

  always #2.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Bus tasks and expectation helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    // A noted read that never reached its data phase is a miss
    if (exp_v.size() != 0)
      fail_count++;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hready !== 1'b1 && n < 16)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (hready !== 1'b1)
    begin
      fail_count++;
      print_verdict();
    end
  endtask

  // One single-word transfer: address phase, then data phase
  task automatic bus_cyc(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  // Read with a noted expectation on data and pins
  task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] m);
    exp_v.push_back(v);
    exp_m.push_back(m);
    bus_cyc(1'b0, a, 32'h0);
  endtask

  task automatic st(input logic [31:0] v);
    rd(32'(STATUS_OFF), v, M);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Packs retry pins, own pull, regulate, bus low, thermal, short, open
  function automatic logic [31:0] ex(logic [1:0] rt, logic pl, logic [1:0] rg,
                                     logic bl, logic th, logic [1:0] sh, logic [1:0] op);
    return {rt, pl, 20'h0, rg, 1'b0, bl, th, sh, op};
  endfunction

  // ----------------------------------------------------------------
  // Monitor: compares each read data phase with the oldest note
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rd_dp)
    begin
      obs = {retry_en, ~oe_n, hrdata[28:0]};
      ev  = (exp_v.size() > 0) ? exp_v.pop_front() : 32'hdead_beef;
      em  = (exp_m.size() > 0) ? exp_m.pop_front() : 32'hffff_ffff;
      compares++;
      if ((obs & em) !== (ev & em))
      begin
        fail_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, obs & em, ev & em);
      end
      // Response is always OKAY and the open-drain data never drives high
      if (hresp !== 1'b0 || bus_o !== 1'b0)
      begin
        fail_count++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, {hresp, bus_o}, 2'h0);
      end
    end
    rd_dp <= hsel & htrans[1] & hready & ~hwrite & ~rst;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    settle(3);
    rst <= 1'b0;
    settle(WT);
    // Registers, read-only status, unmapped place
    rd(32'(CTRL_OFF), 32'h1, 32'h1);
    bus_cyc(1'b1, 32'(CTRL_OFF), 32'h0);
    bus_cyc(1'b1, 32'(STATUS_OFF), 32'hffff_ffff);
    rd(32'(CTRL_OFF), 32'h0, 32'h1);
    rd(32'h8, 32'h0, 32'hffff_ffff);
    settle(4);
    st(ex(0, 0, 0, 0, 0, 0, 0));
    bus_cyc(1'b1, 32'(CTRL_OFF), 32'h1);
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    $display("test 1 done");
    // Open fault on a random channel, retry ignores dimming, recovery
    oh = 2'b01 << ($random(seed) & 1);
    diag  <= 1'b1;
    hr_lo <= oh;
    hr_hi <= ~oh;
    settle(WT);
    st(ex(oh, 1, 0, 1, 0, 0, oh));
    dim <= 2'b00;
    settle(4);
    st(ex(oh, 1, 0, 1, 0, 0, oh));
    dim   <= 2'b11;
    hr_lo <= 2'b00;
    hr_hi <= 2'b11;
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    // Interrupted low headroom never completes the deglitch
    repeat (3)
    begin
      hr_lo <= oh;
      hr_hi <= ~oh;
      settle(6);
      hr_lo <= 2'b00;
      hr_hi <= 2'b11;
      settle(1);
    end
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    $display("test 2 done");
    // Detect enable low, as in low dropout, and dimming low
    diag  <= 1'b0;
    hr_lo <= 2'b11;
    hr_hi <= 2'b00;
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    diag <= 1'b1;
    dim  <= 2'b00;
    settle(WT);
    st(ex(0, 0, 0, 0, 0, 0, 0));
    hr_lo <= 2'b00;
    hr_hi <= 2'b11;
    dim   <= 2'b11;
    diag  <= 1'b0;
    settle(WT);
    $display("test 3 done");
    // Short to ground on direct then shunt output, detect enable low
    for (k = 0; k < 2; k++)
    begin
      sc = 2'b01 << k;
      dlo   <= (k == 0) ? sc : 2'b00;
      slo   <= (k == 1) ? sc : 2'b00;
      sgclr <= ~sc;
      settle(WT);
      st(ex(sc, 1, 0, 1, 0, sc, 0));
      dlo   <= 2'b00;
      slo   <= 2'b00;
      sgclr <= 2'b11;
      settle(WT);
      st(ex(0, 0, 3, 0, 0, 0, 0));
    end
    $display("test 4 done");
    // Thermal shutdown with hysteresis
    t_at   <= 1'b1;
    t_cool <= 1'b0;
    settle(WT);
    st(ex(0, 1, 0, 1, 1, 0, 0));
    t_at <= 1'b0;
    settle(WT);
    st(ex(0, 1, 0, 1, 1, 0, 0));
    t_cool <= 1'b1;
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    $display("test 5 done");
    // Bus pulled low by another driver, then released
    peer_fault <= 1'b1;
    settle(WT);
    st(ex(0, 0, 0, 1, 0, 0, 0));
    peer_fault <= 1'b0;
    settle(6);
    st(ex(0, 0, 0, 0, 0, 0, 0));
    settle(WT);
    st(ex(0, 0, 3, 0, 0, 0, 0));
    $display("test 6 done");
    settle(4);
    print_verdict();
  end
endmodule
